// ---- rtl/refresh_timer_consts.vh ----
/*
 Constants for the refresh interval timer: register byte addresses,
 field positions, reset values and prescaler width.
 Assumes inclusion by bare name from the design file.
*/
`ifndef REFRESH_TIMER_CONSTS_VH
`define REFRESH_TIMER_CONSTS_VH

// Register byte addresses on the AHB-Lite slave (word aligned)
`define ADDR_MODE_CTRL 4'h0
`define ADDR_TIMER_CSR 4'h4
`define ADDR_COUNTER 4'h8
`define ADDR_CONSTANT 4'hC

// Mode control field positions
`define MC_SELF_REFRESH 7
`define MC_PSEUDO_STATIC 6
`define MC_DYNAMIC 5
`define MC_STROBE_MODE 4
`define MC_ADDR_MUX 3
`define MC_PIN_ENABLE 2
`define MC_RESERVED 1
`define MC_CYCLE_ENABLE 0

// Timer control/status field positions
`define CSR_FLAG 7
`define CSR_IRQ_ENABLE 6
`define CSR_CKS_HI 5
`define CSR_CKS_LO 3

// Reset values
`define MODE_CTRL_RESET 8'h02
`define CSR_RESERVED_BITS 3'h7
`define COUNTER_RESET 8'h00
`define CONSTANT_RESET 8'hFF

// Prescaler width, enough for the divide-by-4096 tap
`define PRESCALE_WIDTH 12
`define PRESCALE_ZERO 12'h000

`endif

// ---- rtl/refresh_interval_timer.v ----
/*
 Refresh interval timer: 8-bit up-counter clocked by a divided system
 clock, compared against a constant register. A match sets the flag and
 clears the counter, and either feeds the refresh request path (memory
 modes) or the maskable match interrupt (timer mode). Registers sit on
 an AHB-Lite slave.
 Assumes one 100 MHz clock, an asynchronous active-low reset, standby
 inputs that come from logic on the same clock, and a bus controller
 that answers refresh requests with a grant and a done pulse.
 Both memory enables set is flagged as illegal and acts as a memory mode.
 hsize is not checked: each register sits in the low byte lane of its word.
 Writes land at the end of the data phase; reads answer from flip-flops.
 The strobe pin enable only gates the output enable; the strobe always runs.
*/
// Register access over AHB-Lite and the address map are this design's own decisions.
//
// Contract
// - Pin enable 0 leaves strobe pin undriven; 1 drives refresh strobe.
// - Mode control bit 1 reads as 1, writes ignored.
// - Cycle enable allows refresh cycles; none when both memory enables are 0.
// - Memory enable set locks pin, cycle, clock select, counter, constant writes.
// - Flag sets when counter equals constant.
// - Flag clears only by read-as-1 then write 0; writing 1 no effect.
// - Interrupt enable gates the flag's interrupt request.
// - Interrupt enable held at 0 while any memory enable is 1.
// - Clock select: 000 stop, else divide by 2,8,32,128,512,2048,4096.
// - Match gives refresh request in memory modes, interrupt in timer mode.
// - Status bits 2..0 read as 1, writes ignored.
// - Flag, enable reset on any standby; clock select only on hardware standby.
// - Counter increments per tick, clears on match with flag set.
// - Counter zeroed by reset and either standby.
// - Constant loads all ones on reset, hardware standby; kept in software standby.
// - Timer mode: write constant, then clock select, then interrupt enable.
// - Memory enables decode: 00 timer, dynamic, pseudo-static; both illegal.
// - First request after reset/standby only pends; later runs; extras dropped.
`timescale 1ns/1ps
`include "refresh_timer_consts.vh"

module refresh_interval_timer (
    input wire clk_sys,
    input wire rst_b,
    input wire hw_standby,
    input wire sw_standby,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output wire [31:0] hrdata,
    output wire hreadyout,
    output wire hresp,
    input wire refresh_grant,
    input wire refresh_done,
    output reg refresh_request,
    output reg refresh_strobe_out,
    output wire refresh_strobe_oe_b,
    output wire match_interrupt,
    output wire illegal_mode,
    output wire [1:0] memory_mode,
    output wire strobe_mode_select,
    output wire addr_mux_select,
    output wire self_refresh_select
);

    // Refresh sequencer states, one-hot
    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_PENDING = 3'b010;
    localparam [2:0] ST_CYCLE = 3'b100;

    // Memory mode codes on memory_mode
    localparam [1:0] MODE_TIMER = 2'b00;
    localparam [1:0] MODE_DYNAMIC = 2'b01;
    localparam [1:0] MODE_PSEUDO = 2'b10;

    // Software-visible register state
    reg [7:0] mode_ctrl_reg;
    reg compare_match_flag_reg;
    reg match_irq_enable_reg;
    reg [2:0] counter_clock_select_reg;
    reg [7:0] refresh_tick_counter_reg;
    reg [7:0] refresh_match_constant_reg;

    // Prescaler and flag clear arming
    reg [`PRESCALE_WIDTH-1:0] prescale_reg;
    reg flag_seen_set_reg;

    // Refresh sequencer state
    reg [2:0] refresh_state_reg;
    reg [2:0] refresh_state_next;

    // Bus data-phase capture and read data
    reg wr_pending_reg;
    reg [3:0] wr_addr_reg;
    reg [31:0] rdata_reg;

    // Shared conditions and bus qualifiers
    wire standby_any;
    wire mem_enabled;
    wire tick;
    wire match;
    wire bus_take;
    wire rd_take;

    // Write data, status view and per-register write strobes
    wire [7:0] wdata;
    wire [7:0] csr_value;
    wire mode_write;
    wire csr_write;
    wire counter_write;
    wire constant_write;

    // Refresh event
    wire refresh_run;

    // Prescaler tap select for the counter tick
    function tap_select;
        input [2:0] sel;
        input [`PRESCALE_WIDTH-1:0] pre;
        begin
            // Each tap fires once per full period of its prescaler bits
            case (sel)
                3'h1: tap_select = (pre[0] == 1'b1);
                3'h2: tap_select = (pre[2:0] == 3'h7);
                3'h3: tap_select = (pre[4:0] == 5'h1F);
                3'h4: tap_select = (pre[6:0] == 7'h7F);
                3'h5: tap_select = (pre[8:0] == 9'h1FF);
                3'h6: tap_select = (pre[10:0] == 11'h7FF);
                3'h7: tap_select = (pre == 12'hFFF);
                default: tap_select = 1'b0;
            endcase
        end
    endfunction

    // Read value of the register at a given byte address
    function [7:0] reg_read;
        input [3:0] addr;
        input [7:0] mode;
        input [7:0] csr;
        input [7:0] cnt;
        input [7:0] cst;
        begin
            // Unmapped offsets read as zero
            case (addr)
                `ADDR_MODE_CTRL: reg_read = mode;
                `ADDR_TIMER_CSR: reg_read = csr;
                `ADDR_COUNTER: reg_read = cnt;
                `ADDR_CONSTANT: reg_read = cst;
                default: reg_read = 8'h00;
            endcase
        end
    endfunction

    // Mode decode and shared conditions
    assign standby_any = hw_standby | sw_standby;
    assign mem_enabled = mode_ctrl_reg[`MC_PSEUDO_STATIC] | mode_ctrl_reg[`MC_DYNAMIC];
    assign memory_mode = {mode_ctrl_reg[`MC_PSEUDO_STATIC], mode_ctrl_reg[`MC_DYNAMIC]};
    assign illegal_mode = mode_ctrl_reg[`MC_PSEUDO_STATIC] & mode_ctrl_reg[`MC_DYNAMIC];

    // Plain mode bits handed to the memory-side bus logic
    assign strobe_mode_select = mode_ctrl_reg[`MC_STROBE_MODE];
    assign addr_mux_select = mode_ctrl_reg[`MC_ADDR_MUX];
    assign self_refresh_select = mode_ctrl_reg[`MC_SELF_REFRESH];

    // Counter tick from the prescaler, and the compare
    assign tick = tap_select(counter_clock_select_reg, prescale_reg);
    assign match = (refresh_tick_counter_reg == refresh_match_constant_reg);

    // Status register view with reserved bits reading as ones
    assign csr_value = {compare_match_flag_reg, match_irq_enable_reg,
                        counter_clock_select_reg, `CSR_RESERVED_BITS};

    // AHB-Lite slave: zero wait, always OKAY, writes land in the data phase
    assign bus_take = hsel & hready & htrans[1];
    assign rd_take = bus_take & ~hwrite;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = rdata_reg;
    assign wdata = hwdata[7:0];

    // Write strobes; counter and constant lock as whole registers
    assign mode_write = wr_pending_reg & (wr_addr_reg == `ADDR_MODE_CTRL);
    assign csr_write = wr_pending_reg & (wr_addr_reg == `ADDR_TIMER_CSR);
    assign counter_write = wr_pending_reg & (wr_addr_reg == `ADDR_COUNTER) & ~mem_enabled;
    assign constant_write = wr_pending_reg & (wr_addr_reg == `ADDR_CONSTANT)
                            & ~mem_enabled;

    // Address phase capture and read data
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            wr_pending_reg <= 1'b0;
            wr_addr_reg <= 4'h0;
            rdata_reg <= 32'h00000000;
        end else begin
            wr_pending_reg <= bus_take & hwrite;
            // Only the low address nibble is decoded; hsel maps the slave
            if (bus_take) begin
                wr_addr_reg <= haddr[3:0];
            end
            if (rd_take) begin
                rdata_reg <= {24'h000000, reg_read(haddr[3:0], mode_ctrl_reg, csr_value,
                              refresh_tick_counter_reg, refresh_match_constant_reg)};
            end
        end
    end

    // Mode control register; lock applies to pin, cycle, strobe and mux bits
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            mode_ctrl_reg <= `MODE_CTRL_RESET;
        end else if (hw_standby) begin
            mode_ctrl_reg <= `MODE_CTRL_RESET;
        end else if (mode_write) begin
            mode_ctrl_reg[`MC_SELF_REFRESH] <= wdata[`MC_SELF_REFRESH];
            mode_ctrl_reg[`MC_PSEUDO_STATIC] <= wdata[`MC_PSEUDO_STATIC];
            mode_ctrl_reg[`MC_DYNAMIC] <= wdata[`MC_DYNAMIC];
            mode_ctrl_reg[`MC_RESERVED] <= 1'b1;
            // The lock follows the enables as they stood before this write
            if (!mem_enabled) begin
                mode_ctrl_reg[`MC_STROBE_MODE] <= wdata[`MC_STROBE_MODE];
                mode_ctrl_reg[`MC_ADDR_MUX] <= wdata[`MC_ADDR_MUX];
                mode_ctrl_reg[`MC_PIN_ENABLE] <= wdata[`MC_PIN_ENABLE];
                mode_ctrl_reg[`MC_CYCLE_ENABLE] <= wdata[`MC_CYCLE_ENABLE];
            end
        end
    end

    // Clock select survives software standby, not hardware standby
    // A write while a memory mode is on is dropped
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            counter_clock_select_reg <= 3'h0;
        end else if (hw_standby) begin
            counter_clock_select_reg <= 3'h0;
        end else if (csr_write && !mem_enabled) begin
            counter_clock_select_reg <= wdata[`CSR_CKS_HI:`CSR_CKS_LO];
        end
    end

    // Interrupt enable, forced low in memory modes and in standby
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            match_irq_enable_reg <= 1'b0;
        end else if (standby_any || mem_enabled) begin
            match_irq_enable_reg <= 1'b0;
        end else if (csr_write) begin
            match_irq_enable_reg <= wdata[`CSR_IRQ_ENABLE];
        end
    end

    // Flag: set by match, cleared by write 0 after a read as 1; set wins
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            compare_match_flag_reg <= 1'b0;
            flag_seen_set_reg <= 1'b0;
        end else if (standby_any) begin
            compare_match_flag_reg <= 1'b0;
            flag_seen_set_reg <= 1'b0;
        end else begin
            // Any status write ends the read-then-write pair; a read taken
            // in the same cycle arms it again
            if (csr_write) begin
                flag_seen_set_reg <= 1'b0;
            end
            if (rd_take && haddr[3:0] == `ADDR_TIMER_CSR && compare_match_flag_reg) begin
                flag_seen_set_reg <= 1'b1;
            end
            // A match in the clearing cycle keeps the flag set
            if (match && tick) begin
                compare_match_flag_reg <= 1'b1;
            end else if (csr_write && flag_seen_set_reg && !wdata[`CSR_FLAG]) begin
                compare_match_flag_reg <= 1'b0;
            end
        end
    end

    // Prescaler runs only while a clock source is selected
    // Held at zero when stopped, so the first tick comes a full period later
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            prescale_reg <= `PRESCALE_ZERO;
        end else if (standby_any || counter_clock_select_reg == 3'h0) begin
            prescale_reg <= `PRESCALE_ZERO;
        end else begin
            prescale_reg <= prescale_reg + 12'h001;
        end
    end

    // Counter: increments on tick, clears on match, zeroed in standby
    // A bus write takes priority over a tick in the same cycle
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            refresh_tick_counter_reg <= `COUNTER_RESET;
        end else if (standby_any) begin
            refresh_tick_counter_reg <= `COUNTER_RESET;
        end else if (counter_write) begin
            refresh_tick_counter_reg <= wdata;
        end else if (tick) begin
            if (match) begin
                refresh_tick_counter_reg <= `COUNTER_RESET;
            end else begin
                refresh_tick_counter_reg <= refresh_tick_counter_reg + 8'h01;
            end
        end
    end

    // Constant register, kept through software standby
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            refresh_match_constant_reg <= `CONSTANT_RESET;
        end else if (hw_standby) begin
            refresh_match_constant_reg <= `CONSTANT_RESET;
        end else if (constant_write) begin
            refresh_match_constant_reg <= wdata;
        end
    end

    // Match interrupt level, timer mode only
    assign match_interrupt = compare_match_flag_reg & match_irq_enable_reg
                             & ~mem_enabled;

    // A refresh event: memory mode, cycles enabled, counter match
    assign refresh_run = mem_enabled & mode_ctrl_reg[`MC_CYCLE_ENABLE]
                         & match & tick;

    // Refresh sequencer next state
    always @* begin
        refresh_state_next = refresh_state_reg;
        case (refresh_state_reg)
            ST_IDLE: begin
                if (refresh_run) begin
                    refresh_state_next = ST_PENDING;
                end
            end
            ST_PENDING: begin
                if (refresh_run) begin
                    refresh_state_next = ST_CYCLE;
                end
            end
            ST_CYCLE: begin
                if (refresh_done) begin
                    refresh_state_next = ST_PENDING;
                end
            end
            default: refresh_state_next = ST_IDLE;
        endcase
        // Leaving a memory mode or disabling cycles drops any pending request
        if (!mem_enabled || !mode_ctrl_reg[`MC_CYCLE_ENABLE]) begin
            refresh_state_next = ST_IDLE;
        end
    end

    // Sequencer state, request and strobe registers
    // The request falls once the grant is seen; the strobe follows the grant
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            refresh_state_reg <= ST_IDLE;
            refresh_request <= 1'b0;
            refresh_strobe_out <= 1'b1;
        end else if (standby_any) begin
            refresh_state_reg <= ST_IDLE;
            refresh_request <= 1'b0;
            refresh_strobe_out <= 1'b1;
        end else begin
            refresh_state_reg <= refresh_state_next;
            refresh_request <= (refresh_state_next == ST_CYCLE) & ~refresh_grant;
            refresh_strobe_out <= ~((refresh_state_next == ST_CYCLE) & refresh_grant);
        end
    end

    // Strobe pin driven only when enabled, enable active low
    assign refresh_strobe_oe_b = ~mode_ctrl_reg[`MC_PIN_ENABLE];

endmodule // refresh_interval_timer

// ---- sim/refresh_bus_partner.sv ----
/*
 Bus controller model that answers refresh requests with a grant and a done pulse.
 Assumes the timer's clock and reset; grant latency comes from the bench.
*/
`timescale 1ns/1ps
module refresh_bus_partner (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic refresh_request,
    input wire logic [3:0] grant_delay,
    output logic refresh_grant,
    output logic refresh_done
);
    logic [3:0] wait_cnt;
    // Waits grant_delay cycles, grants, holds the cycle three clocks, then signals done
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            wait_cnt <= 4'h0;
            refresh_grant <= 1'b0;
            refresh_done <= 1'b0;
        end else begin
            refresh_done <= 1'b0;
            if (!refresh_grant && refresh_request) begin
                wait_cnt <= (wait_cnt == grant_delay) ? 4'h0 : wait_cnt + 4'h1;
                refresh_grant <= (wait_cnt == grant_delay);
            end else if (refresh_grant) begin
                wait_cnt <= (wait_cnt == 4'h2) ? 4'h0 : wait_cnt + 4'h1;
                refresh_grant <= (wait_cnt != 4'h2);
                refresh_done <= (wait_cnt == 4'h2);
            end
        end
    end
endmodule // refresh_bus_partner

// ---- sim/refresh_interval_timer_monitor.sv ----
/*
 Port checker for the refresh interval timer, bound to the design top.
 Assumes one clock domain and the asynchronous active-low reset.
*/
`timescale 1ns/1ps
module refresh_interval_timer_monitor (
    input wire clk_sys,
    input wire rst_b,
    input wire hw_standby,
    input wire sw_standby,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire hready,
    input wire [31:0] hrdata,
    input wire hreadyout,
    input wire hresp,
    input wire refresh_grant,
    input wire refresh_request,
    input wire refresh_strobe_out,
    input wire match_interrupt,
    input wire illegal_mode,
    input wire [1:0] memory_mode
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    // Read address phases of the two control registers
    sequence rd_mode;
        hsel && hready && htrans[1] && !hwrite && haddr[3:0] == 4'h0;
    endsequence
    sequence rd_csr;
        hsel && hready && htrans[1] && !hwrite && haddr[3:0] == 4'h4;
    endsequence
    AST_MODE_RSV: assert property (rd_mode |=> hrdata[1])
        else $error("mode reserved bit read as zero");
    AST_CSR_RSV: assert property (rd_csr |=> hrdata[2:0] == 3'h7)
        else $error("status reserved bits not ones");
    AST_UPPER: assert property (hrdata[31:8] == 24'h0)
        else $error("read data upper bits set");
    AST_OKAY: assert property (hreadyout && !hresp)
        else $error("slave stalled or erred");
    AST_NO_REQ: assert property (memory_mode == 2'h0 && $past(memory_mode) == 2'h0
        |-> !refresh_request)
        else $error("refresh request in timer mode");
    AST_IRQ_MASK: assert property (match_interrupt |-> memory_mode == 2'h0)
        else $error("match interrupt in memory mode");
    AST_ILLEGAL: assert property (illegal_mode == (memory_mode == 2'h3))
        else $error("illegal mode decode wrong");
    AST_STROBE: assert property (!refresh_strobe_out |-> $past(refresh_grant))
        else $error("strobe low without grant");
    AST_REQ_HOLD: assert property (refresh_request && !refresh_grant && !hw_standby
        && !sw_standby |=> refresh_request)
        else $error("request dropped before grant");
endmodule // refresh_interval_timer_monitor

bind refresh_interval_timer refresh_interval_timer_monitor refresh_interval_timer_monitor_inst (
    .clk_sys, .rst_b, .hw_standby, .sw_standby, .hsel, .haddr, .htrans, .hwrite, .hready,
    .hrdata, .hreadyout, .hresp, .refresh_grant, .refresh_request, .refresh_strobe_out,
    .match_interrupt, .illegal_mode, .memory_mode);

// ---- sim/tb_top.sv ----
/*
 Self-checking bench for the refresh interval timer over AHB-Lite.
 Assumes the bus controller model and the bound port checker.
*/
`timescale 1ns/1ps
module tb_top;
    logic clk_sys = 0, rst_b = 0, hw_standby = 0, sw_standby = 0, hsel = 0, hwrite = 0;
    logic [31:0] haddr = 0, hwdata = 0, q;
    logic [1:0] htrans = 0;
    logic [2:0] hsize = 3'h2;
    logic [3:0] grant_delay = 4'h0;
    wire [31:0] hrdata;
    wire [1:0] memory_mode;
    wire hreadyout, hresp, refresh_grant, refresh_done, refresh_request;
    wire refresh_strobe_out, refresh_strobe_oe_b, match_interrupt, illegal_mode;
    wire strobe_mode_select, addr_mux_select, self_refresh_select;
    int miscompares = 0, checks = 0, i, k;
    // Rows: write flag, offset, write data, expected read
    logic [20:0] rows [10] = '{{1'b0, 4'h0, 8'h00, 8'h02}, {1'b0, 4'h4, 8'h00, 8'h07},
        {1'b0, 4'h8, 8'h00, 8'h00}, {1'b0, 4'hC, 8'h00, 8'hFF}, {1'b1, 4'hC, 8'h5A, 8'h5A},
        {1'b1, 4'h8, 8'h33, 8'h33}, {1'b1, 4'h0, 8'h9D, 8'h9F}, {1'b1, 4'h0, 8'h00, 8'h02},
        {1'b1, 4'h4, 8'h87, 8'h07}, {1'b1, 4'h4, 8'h78, 8'h7F}};

    // Free-running system clock
    always #5 clk_sys = ~clk_sys;

    refresh_interval_timer refresh_interval_timer_inst (.clk_sys, .rst_b, .hw_standby,
        .sw_standby, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
        .hrdata, .hreadyout, .hresp, .refresh_grant, .refresh_done, .refresh_request,
        .refresh_strobe_out, .refresh_strobe_oe_b, .match_interrupt, .illegal_mode,
        .memory_mode, .strobe_mode_select, .addr_mux_select, .self_refresh_select);
    refresh_bus_partner refresh_bus_partner_inst (.clk_sys, .rst_b, .refresh_request,
        .grant_delay, .refresh_grant, .refresh_done);

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            miscompares++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask

    // One single AHB-Lite transfer; read data lands in q
    task automatic xfer(input logic [3:0] a, input logic w, input logic [7:0] d);
        hsel <= 1;
        haddr <= {28'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        @(posedge clk_sys);
        while (hreadyout !== 1'b1) @(posedge clk_sys);
        hsel <= 0;
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        @(posedge clk_sys);
        while (hreadyout !== 1'b1) @(posedge clk_sys);
        q = hrdata;
    endtask

    task automatic rdchk(input string n, input logic [3:0] a, input logic [7:0] e);
        xfer(a, 1'b0, 8'h00);
        chk(n, {24'h0, e}, q);
    endtask

    task automatic standby(input logic hw);
        if (hw) hw_standby <= 1;
        else sw_standby <= 1;
        repeat (2) @(posedge clk_sys);
        hw_standby <= 0;
        sw_standby <= 0;
        @(posedge clk_sys);
    endtask

    task automatic test_done;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // Main sequence
    initial begin
        repeat (10) @(posedge clk_sys);
        rst_b <= 1;
        @(posedge clk_sys);
        for (i = 0; i < 10; i++) begin
            if (rows[i][20]) xfer(rows[i][19:16], 1'b1, rows[i][15:8]);
            rdchk("row", rows[i][19:16], rows[i][7:0]);
        end
        for (i = 1; i < 8; i++) begin
            xfer(4'h4, 1'b1, {2'b00, i[2:0], 3'h0});
            rdchk("clock select", 4'h4, {2'b00, i[2:0], 3'h7});
        end
        // Interval timer: constant, clock, then enable
        xfer(4'hC, 1'b1, 8'h03);
        xfer(4'h8, 1'b1, 8'h00);
        xfer(4'h4, 1'b1, 8'h08);
        repeat (20) @(posedge clk_sys);
        rdchk("flag", 4'h4, 8'h8F);
        chk("masked irq", 0, match_interrupt);
        xfer(4'h4, 1'b1, 8'h48);
        for (k = 0; k < 50 && match_interrupt !== 1'b1; k++) @(posedge clk_sys);
        chk("irq", 1, match_interrupt);
        xfer(4'h4, 1'b1, 8'hC0);
        xfer(4'h4, 1'b1, 8'h40);
        rdchk("flag kept", 4'h4, 8'hC7);
        xfer(4'h4, 1'b1, 8'h40);
        rdchk("flag clear", 4'h4, 8'h47);
        chk("irq off", 0, match_interrupt);
        // Software standby keeps clock select and constant
        xfer(4'h8, 1'b1, 8'h20);
        xfer(4'h4, 1'b1, 8'h68);
        standby(1'b0);
        rdchk("sw csr", 4'h4, 8'h2F);
        rdchk("sw counter", 4'h8, 8'h00);
        rdchk("sw constant", 4'hC, 8'h03);
        // Dynamic memory mode, set up in the required order
        xfer(4'h4, 1'b1, 8'h08);
        xfer(4'h0, 1'b1, 8'h25);
        #1; // Let the write land before looking at the pins
        chk("mode", 2'h1, memory_mode);
        chk("pin enable", 0, refresh_strobe_oe_b);
        xfer(4'hC, 1'b1, 8'h77);
        rdchk("locked constant", 4'hC, 8'h03);
        xfer(4'h4, 1'b1, 8'h70);
        xfer(4'h4, 1'b0, 8'h00);
        chk("locked csr", 8'h0F, q & 8'h7F);
        // Strobe and mux bits stay locked; self-refresh select stays writable
        xfer(4'h0, 1'b1, 8'hBD);
        #1;
        chk("sel", 3'h4, {self_refresh_select, strobe_mode_select, addr_mux_select});
        rdchk("locked mode", 4'h0, 8'hA7);
        for (i = 0; i < 2; i++) begin
            grant_delay <= i ? 4'h5 : 4'h0;
            for (k = 0; k < 200 && refresh_strobe_out !== 1'b0; k++) @(posedge clk_sys);
            chk("strobe low", 0, refresh_strobe_out);
            for (k = 0; k < 50 && refresh_strobe_out !== 1'b1; k++) @(posedge clk_sys);
        end
        // Hardware standby reinitialises mode control, constant and status registers
        standby(1'b1);
        rdchk("hw mode", 4'h0, 8'h02);
        rdchk("hw constant", 4'hC, 8'hFF);
        rdchk("hw csr", 4'h4, 8'h07);
        xfer(4'h0, 1'b1, 8'h60);
        #1;
        chk("illegal", 1, illegal_mode);
        test_done;
    end

    // Watchdog against a hung handshake
    initial begin
        repeat (20000) @(posedge clk_sys);
        miscompares++;
        test_done;
    end
endmodule // tb_top
